// >>> dv/rx_demod_model.sv
// Receiver model: sink of the framed stream that decodes each header and
// judges every symbol. Assumes modcod 0 marks a dummy frame and that the
// two low modcod bits carry the constellation, as the bench sends them.
`timescale 1ns/100ps
`default_nettype none
module rx_demod_model
    import phy_frame_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Framed stream
    input  wire logic             stall_i,
    input  wire logic             valid_i,
    input  wire logic             sof_i,
    input  wire logic             hdr_i,
    input  wire logic             pilot_i,
    input  wire logic             dummy_i,
    input  wire logic [SYM_W-1:0] si_i,
    input  wire logic [SYM_W-1:0] sq_i,
    output logic                  ready_o,
    // Results
    output int                    frames_o,
    output int                    bad_o,
    output int                    len_o
);
    logic [89:0]      hb;
    logic [17:0]      x, y;
    logic [2:0]       tick = 3'h0;
    logic             ok, pil, dm;
    logic [SYM_W-1:0] ui, uq;
    int               pos, dn, flen, p;

    // The length comes from the header alone, so a lost payload still
    // leaves the next frame start known.
    function automatic int frame_len(input logic [89:0] h);
        logic [63:0] c;
        logic [4:0]  mc;
        int          sl;
        c = h[63:0] ^ HDR_SCRAMBLE;
        for (int m = 0; m < 5; m++)
            mc[m] = c[63 - (2 << m)] ^ c[63];
        sl = (mc == 5'h00) ? 36 : (c[63] ? 16200 : 64800) / ((mc[1:0] + 2) * 90);
        return 90 + sl * 90 + ((c[63] ^ c[62]) ? (sl - 1) / 16 * 36 : 0);
    endfunction : frame_len

    // Stall one cycle in eight when asked, so the builder must hold its output.
    assign ready_o = !stall_i || tick != 3'h0;

    // Expected symbol from position, descrambled with the local sequence.
    always_comb begin
        p = pos - HDR_LEN;
        flen = frame_len(hb);
        dm = hb[63:0] == HDR_SCRAMBLE;
        pil = (^(hb[63:62] ^ HDR_SCRAMBLE[63:62])) && p >= 0 && p % 1476 >= 1440;
        case ({x[4] ^ x[6] ^ x[15] ^ y[5] ^ y[6] ^ (^y[17:8]), x[0] ^ y[0]})
            2'h0: {ui, uq} = {si_i, sq_i};
            2'h1: {ui, uq} = {sq_i, -si_i};
            2'h2: {ui, uq} = {-si_i, -sq_i};
            default: {ui, uq} = {-sq_i, si_i};
        endcase
        ok = (sof_i == (pos == 0)) && (hdr_i == (pos < HDR_LEN));
        if (pos < HDR_LEN)
            ok = ok && (sq_i == AMP || sq_i == -AMP) && si_i == (pos[0] ? -sq_i : sq_i);
        else
            ok = ok && pilot_i == pil && dummy_i == dm && {ui, uq} == ((pil || dm) ?
                 {AMP, AMP} : {1'b0, dn[6:0], 8'h40 ^ {1'b0, dn[6:0]}});
    end

    // Frame tracking; the scrambler restarts during every header.
    always_ff @(posedge mclk_i) begin
        tick <= tick + 3'h1;
        if (sys_rst_i) begin
            pos <= 0;
            frames_o <= 0;
            bad_o <= 0;
            len_o <= 0;
        end else if (valid_i && ready_o) begin
            if (ok !== 1'b1)
                bad_o <= bad_o + 1;
            if (pos < HDR_LEN) begin
                hb[89 - pos] <= sq_i[SYM_W-1];
                x <= SCR_X_INIT;
                y <= SCR_Y_INIT;
                dn <= 0;
            end else begin
                x <= {x[0] ^ x[7], x[17:1]};
                y <= {y[0] ^ y[5] ^ y[7] ^ y[10], y[17:1]};
                dn <= dn + ((pil || dm) ? 0 : 1);
            end
            if (pos >= HDR_LEN && pos + 1 == flen) begin
                frames_o <= frames_o + 1;
                len_o <= flen;
                pos <= 0;
            end else
                pos <= pos + 1;
        end
    end
endmodule : rx_demod_model
`default_nettype wire

// >>> dv/testbench.sv
// Testbench: feeds mapped code blocks to the frame builder and judges the
// framed stream through the receiver model. Assumes one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import phy_frame_pkg::*;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, pilot_en_i = 1'b0, dummy_en_i = 1'b0;
    logic in_valid_i = 1'b0, in_first_i = 1'b0, in_short_i = 1'b0, stall = 1'b0;
    logic [1:0] in_mod_i = 2'h0;
    logic [4:0] in_modcod_i = 5'h00;
    logic [SYM_W-1:0] in_i_i = 8'h00, in_q_i = 8'h00, out_i_o, out_q_o;
    logic in_ready_o, interleave_o, out_valid_o, out_ready_i;
    logic out_sof_o, out_hdr_o, out_pilot_o, out_dummy_o;
    int   frames, bad, len, err_count = 0, n_checks = 0;

    phy_frame_builder i_dut (.mclk_i, .sys_rst_i, .pilot_en_i, .dummy_en_i, .in_valid_i,
        .in_ready_o, .in_first_i, .in_short_i, .in_mod_i, .in_modcod_i, .in_i_i, .in_q_i,
        .interleave_o, .out_valid_o, .out_ready_i, .out_i_o, .out_q_o, .out_sof_o,
        .out_hdr_o, .out_pilot_o, .out_dummy_o);
    rx_demod_model i_rx (.mclk_i, .sys_rst_i, .stall_i(stall), .valid_i(out_valid_o),
        .sof_i(out_sof_o), .hdr_i(out_hdr_o), .pilot_i(out_pilot_o), .dummy_i(out_dummy_o),
        .si_i(out_i_o), .sq_i(out_q_o), .ready_o(out_ready_i), .frames_o(frames),
        .bad_o(bad), .len_o(len));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // Inputs move 2 ns after the edge so the builder never sees a race.
    task automatic step;
        @(posedge mclk_i);
        #2;
    endtask : step

    function automatic int slots(input logic s, input logic [1:0] m);
        return (s ? 16200 : 64800) / ((m + 2) * 90);
    endfunction : slots

    function automatic int exp_len(input logic s, input logic [1:0] m, input logic p);
        return 90 + slots(s, m) * 90 + (p ? (slots(s, m) - 1) / 16 * 36 : 0);
    endfunction : exp_len

    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (frames < n && k < 40000) begin
            step;
            k++;
        end
        if (k == 40000) begin
            err_count++;
            end_sim;
        end
    endtask : wait_frames

    // One code block; each symbol is held until in_ready_o takes it.
    task automatic send_block(input logic s, input logic [1:0] m);
        int k;
        for (int n = 0; n < slots(s, m) * 90; n++) begin
            {in_valid_i, in_first_i, in_short_i, in_mod_i} = {1'b1, n == 0, s, m};
            in_modcod_i = {3'h1, m};
            in_i_i = {1'b0, n[6:0]};
            in_q_i = {1'b0, n[6:0]} ^ 8'h40;
            k = 0;
            while (!in_ready_o && k < 1000) begin
                step;
                k++;
            end
            if (k == 1000) begin
                err_count++;
                end_sim;
            end
            step;
        end
        // Let one edge pass idle so a following block never re-raises valid at once.
        in_valid_i = 1'b0;
        step;
    endtask : send_block

    task automatic t_dummy;
        int k;
        k = 0;
        dummy_en_i = 1'b1;
        while (!out_valid_o && k < 100) begin
            step;
            k++;
        end
        dummy_en_i = 1'b0;
        if (k == 100) begin
            err_count++;
            end_sim;
        end
        wait_frames(frames + 1);
        check(len, 90 + 36 * 90);
        check(bad, 0);
    endtask : t_dummy

    // Every constellation in short frames with pilots on.
    task automatic t_modes;
        int f;
        pilot_en_i = 1'b1;
        for (int m = 0; m < 4; m++) begin
            f = frames;
            send_block(1'b1, m[1:0]);
            check(interleave_o, m != 0);
            wait_frames(f + 1);
            check(len, exp_len(1'b1, m[1:0], 1'b1));
            check(bad, 0);
        end
        pilot_en_i = 1'b0;
    endtask : t_modes

    // Normal then short back to back, sink stalling, no extra frames after.
    task automatic t_mixed;
        int f;
        f = frames;
        stall = 1'b1;
        send_block(1'b0, 2'h3);
        send_block(1'b1, 2'h1);
        wait_frames(f + 2);
        check(len, exp_len(1'b1, 2'h1, 1'b0));
        repeat (200) step;
        check(frames, f + 2);
        check(bad, 0);
        stall = 1'b0;
    endtask : t_mixed

    initial begin
        repeat (16) step;
        check(out_valid_o, 1'b0);
        check(in_ready_o, 1'b0);
        sys_rst_i = 1'b0;
        t_dummy;
        t_modes;
        t_mixed;
        end_sim;
    end
endmodule : testbench
`default_nettype wire

// >>> src/phy_frame_builder.sv
// Physical-layer frame builder: header, payload slots, pilots, dummy frames,
// energy-dispersal scrambling. Assumes the mapper delivers each code block as
// a run of symbols with in_first_i on the first, and a sink with valid/ready.
//
// Function
// (R1) Each frame carries exactly one normal or short code block as payload.
// (R2) Every frame opens with a 90-symbol header in pi/2-rotated binary form.
// (R3) The payload without pilots spans a whole number of 90-symbol slots.
// (R4) The header bits are protected by a rate 7/64 block code, not the payload code.
// (R5) The header signals modulation, code rate, frame length and pilot presence.
// (R6) Mode is fixed within a frame and may change, or mix lengths, between frames.
// (R7) Bits are interleaved before mapping for 8PSK, 16APSK and 32APSK, not QPSK.
// (R8) A code block maps to its length over the bits per symbol of its constellation.
// (R9) With no data ready a dummy frame may be sent to keep the stream continuous.
// (R10) With pilots on, 36 pilot symbols follow every 1440 data symbols after the header.
// (R11) Output is built of 90-symbol slots with the header slot ahead of the payload.
// (R12) Payload slot count depends on frame length and constellation order.
// (R13) One frame is built per code block and the output is scrambled.
// (R14) The receiver derives frame length from the header to find the next frame.
// (R15) Payload and pilots, not the header, are rotated by a period-262143 complex sequence.
// (R16) One symbol moves per accepted cycle and a marker flags the first header symbol.
// (R17) The scrambling sequence restarts at the first payload symbol of every frame.
`timescale 1ns/100ps
`default_nettype none
module phy_frame_builder
    import phy_frame_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Configuration
    input  wire logic             pilot_en_i,
    input  wire logic             dummy_en_i,
    // Mapped symbols from the mapper
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic             in_first_i,
    input  wire logic             in_short_i,
    input  wire logic [1:0]       in_mod_i,
    input  wire logic [4:0]       in_modcod_i,
    input  wire logic [SYM_W-1:0] in_i_i,
    input  wire logic [SYM_W-1:0] in_q_i,
    // Mode request to the mapper
    output logic                  interleave_o,
    // Framed symbol stream
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [SYM_W-1:0]      out_i_o,
    output logic [SYM_W-1:0]      out_q_o,
    output logic                  out_sof_o,
    output logic                  out_hdr_o,
    output logic                  out_pilot_o,
    output logic                  out_dummy_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Payload slots for a constellation and frame length.
    function automatic logic [8:0] slots_of(input logic [1:0] m, input logic s);
        case ({s, m})
            3'h0:    slots_of = SLOTS_N_QPSK;
            3'h1:    slots_of = SLOTS_N_8PSK;
            3'h2:    slots_of = SLOTS_N_16A;
            3'h3:    slots_of = SLOTS_N_32A;
            3'h4:    slots_of = SLOTS_S_QPSK;
            3'h5:    slots_of = SLOTS_S_8PSK;
            3'h6:    slots_of = SLOTS_S_16A;
            default: slots_of = SLOTS_S_32A;
        endcase
    endfunction : slots_of

    // Quarter-turn rotation of a symbol by r times 90 degrees.
    function automatic logic [2*SYM_W-1:0] rotate(input logic [1:0] r,
                                                  input logic [SYM_W-1:0] si,
                                                  input logic [SYM_W-1:0] sq);
        case (r)
            2'h0:    rotate = {si, sq};
            2'h1:    rotate = {SYM_W'(-sq), si};
            2'h2:    rotate = {SYM_W'(-si), SYM_W'(-sq)};
            default: rotate = {sq, SYM_W'(-si)};
        endcase
    endfunction : rotate

    // ------------------------------------------------------------
    // Input holding stage
    // ------------------------------------------------------------
    logic [IN_W-1:0] fe0, fe1, next_fe0, next_fe1, in_word;
    logic [1:0]      fcnt, next_fcnt;
    logic            next_in_ready, push, pop, head_v;

    assign in_word = {in_first_i, in_short_i, in_mod_i, in_modcod_i, in_i_i, in_q_i};
    assign push    = in_valid_i && in_ready_o;
    assign head_v  = (fcnt != 2'h0);

    // Two entries let the registered ready run at full rate without overflow.
    always_comb begin
        next_fe0  = fe0;
        next_fe1  = fe1;
        next_fcnt = fcnt + {1'b0, push} - {1'b0, pop};
        if (pop) begin
            next_fe0 = fe1;
        end
        if (push) begin
            if ((fcnt - {1'b0, pop}) == 2'h0) begin
                next_fe0 = in_word;
            end else begin
                next_fe1 = in_word;
            end
        end
        next_in_ready = (next_fcnt < 2'h2);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fe0        <= '0;
            fe1        <= '0;
            fcnt       <= 2'h0;
            in_ready_o <= 1'b0;
        end else begin
            fe0        <= next_fe0;
            fe1        <= next_fe1;
            fcnt       <= next_fcnt;
            in_ready_o <= next_in_ready;
        end
    end

    // ------------------------------------------------------------
    // Framing state machine and output stage
    // ------------------------------------------------------------
    state_t          state, next_state;
    logic [6:0]      sym_cnt, next_sym_cnt;
    logic [8:0]      slot_cnt, next_slot_cnt, slot_total, next_slot_total;
    logic [3:0]      pil_slot, next_pil_slot;
    logic [1:0]      fmod, next_fmod;
    logic            fdummy, next_fdummy, fpil, next_fpil;
    logic [17:0]     sx, sy, next_sx, next_sy;
    logic            advance, emit, e_sof, e_hdr, e_pil, hbit, hdr_load, z0, z1;
    logic [SYM_W-1:0] e_i, e_q, hs, ri, rq;
    logic [2*SYM_W-1:0] rot;
    logic [HDR_LEN-1:0] hdr_bits;
    logic            next_interleave;

    assign advance = !out_valid_o || out_ready_i;
    assign z0 = sx[0] ^ sy[0];
    assign z1 = sx[4] ^ sx[6] ^ sx[15] ^ (^sy[17:8]) ^ sy[6] ^ sy[5];

    phy_header_encoder u_hdr (
        .mclk_i     (mclk_i),
        .sys_rst_i  (sys_rst_i),
        .load_i     (hdr_load),
        .modcod_i   (dummy_en_i && !head_v ? 5'h00 : fe0[F_MODCOD +: 5]),
        .short_i    (head_v && fe0[F_SHORT]),
        .pilots_i   (head_v && pilot_en_i),
        .hdr_bits_o (hdr_bits)
    );

    // Next values of the framer; output only moves when the sink can take it.
    always_comb begin
        next_state = state;      next_sym_cnt = sym_cnt;   next_slot_cnt = slot_cnt;
        next_slot_total = slot_total; next_pil_slot = pil_slot; next_fmod = fmod;
        next_fdummy = fdummy;    next_fpil = fpil;          next_sx = sx;  next_sy = sy;
        pop = 1'b0;  emit = 1'b0;  e_sof = 1'b0;  e_hdr = 1'b0;  e_pil = 1'b0;
        hdr_load = 1'b0;  ri = '0;  rq = '0;  e_i = '0;  e_q = '0;
        hbit = hdr_bits[7'(HDR_LEN-1) - sym_cnt];
        hs   = hbit ? SYM_W'(-AMP) : AMP;
        case (state)
            ST_START: begin
                if (advance && head_v && !fe0[F_FIRST]) begin
                    pop = 1'b1;                               // Stray symbol, dropped. R13
                end else if (advance && (head_v || dummy_en_i)) begin
                    hdr_load        = 1'b1;
                    next_fdummy     = !head_v;                // R9
                    next_fpil       = head_v && pilot_en_i;   // R10
                    next_fmod       = head_v ? fe0[F_MOD +: 2] : MOD_QPSK; // R6
                    next_slot_total = head_v ? slots_of(fe0[F_MOD +: 2], fe0[F_SHORT])
                                             : DUMMY_SLOTS;   // R1 R8 R12
                    next_sym_cnt    = 7'h00;
                    next_state      = ST_HDR;
                end
            end
            ST_HDR: begin
                if (advance) begin
                    emit  = 1'b1;
                    e_hdr = 1'b1;
                    e_sof = (sym_cnt == 7'h00);               // R16
                    e_i   = sym_cnt[0] ? SYM_W'(-hs) : hs;   // R2
                    e_q   = hs;
                    if (sym_cnt == 7'(HDR_LEN-1)) begin       // R11
                        next_sym_cnt  = 7'h00;
                        next_slot_cnt = 9'h000;
                        next_pil_slot = 4'h0;
                        next_sx       = SCR_X_INIT;           // R17
                        next_sy       = SCR_Y_INIT;
                        next_state    = ST_DATA;
                    end else begin
                        next_sym_cnt = sym_cnt + 7'h01;
                    end
                end
            end
            ST_DATA: begin
                if (advance && (fdummy || head_v)) begin
                    emit = 1'b1;
                    pop  = !fdummy;
                    ri   = fdummy ? AMP : fe0[F_I +: SYM_W];
                    rq   = fdummy ? AMP : fe0[SYM_W-1:0];
                    if (sym_cnt == 7'(SLOT_LEN-1)) begin      // R3
                        next_sym_cnt = 7'h00;
                        if (slot_cnt == slot_total - 9'h001) begin
                            next_state = ST_START;            // R13
                        end else begin
                            next_slot_cnt = slot_cnt + 9'h001;
                            next_pil_slot = pil_slot + 4'h1;
                            if (fpil && pil_slot == PILOT_EVERY) begin
                                next_pil_slot = 4'h0;
                                next_state    = ST_PILOT;     // R10
                            end
                        end
                    end else begin
                        next_sym_cnt = sym_cnt + 7'h01;
                    end
                end
            end
            ST_PILOT: begin
                if (advance) begin
                    emit  = 1'b1;
                    e_pil = 1'b1;
                    ri    = AMP;
                    rq    = AMP;
                    if (sym_cnt == 7'(PILOT_LEN-1)) begin
                        next_sym_cnt = 7'h00;
                        next_state   = ST_DATA;
                    end else begin
                        next_sym_cnt = sym_cnt + 7'h01;
                    end
                end
            end
            default: begin
                next_state = ST_START;
            end
        endcase
        // Payload and pilots are rotated and advance the Gold sequence.
        rot = rotate({z1, z0}, ri, rq);                        // R15
        if (emit && !e_hdr) begin
            e_i     = rot[2*SYM_W-1:SYM_W];
            e_q     = rot[SYM_W-1:0];
            next_sx = {sx[7] ^ sx[0], sx[17:1]};
            next_sy = {sy[10] ^ sy[7] ^ sy[5] ^ sy[0], sy[17:1]};
        end
        next_interleave = (next_fmod != MOD_QPSK);             // R7
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= ST_START;  sym_cnt <= 7'h00;  slot_cnt <= 9'h000;
            slot_total <= 9'h000;  pil_slot <= 4'h0;  fmod <= 2'h0;
            fdummy <= 1'b0;  fpil <= 1'b0;  sx <= SCR_X_INIT;  sy <= SCR_Y_INIT;
            interleave_o <= 1'b0;  out_valid_o <= 1'b0;  out_i_o <= '0;  out_q_o <= '0;
            out_sof_o <= 1'b0;  out_hdr_o <= 1'b0;  out_pilot_o <= 1'b0;
            out_dummy_o <= 1'b0;
        end else begin
            state <= next_state;  sym_cnt <= next_sym_cnt;  slot_cnt <= next_slot_cnt;
            slot_total <= next_slot_total;  pil_slot <= next_pil_slot;  fmod <= next_fmod;
            fdummy <= next_fdummy;  fpil <= next_fpil;  sx <= next_sx;  sy <= next_sy;
            interleave_o <= next_interleave;
            if (advance) begin
                out_valid_o <= emit;  out_i_o <= e_i;  out_q_o <= e_q;
                out_sof_o <= e_sof;  out_hdr_o <= e_hdr;  out_pilot_o <= e_pil;
                out_dummy_o <= emit && !e_hdr && fdummy;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sof_on_hdr: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R16
        out_valid_o |-> (!out_sof_o || out_hdr_o)) else $error("Marker off header.");
    a_hold_stalled: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R16
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_i_o) && $stable(out_q_o))
        else $error("Output changed under stall.");
    a_hdr_length: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R2
        state == ST_HDR |-> sym_cnt < 7'(HDR_LEN)) else $error("Header overran.");
    a_hdr_exit: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R11
        state == ST_HDR && advance && sym_cnt == 7'd89 |=> state == ST_DATA && sym_cnt == 7'd0)
        else $error("Header did not end at 90.");
    a_pilot_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
        $rose(state == ST_PILOT) |-> fpil && $past(pil_slot) == 4'd15
        && $past(sym_cnt) == 7'd89) else $error("Pilot block misplaced.");
    a_pilot_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
        state == ST_PILOT |-> sym_cnt < 7'd36) else $error("Pilot block too long.");
    a_frame_end: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R3
        state == ST_DATA ##1 state == ST_START |-> $past(sym_cnt) == 7'd89
        && $past(slot_cnt) == slot_total - 9'd1) else $error("Payload not whole slots.");
    a_scr_restart: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
        $past(state) == ST_HDR && state == ST_DATA && slot_cnt == 9'd0 && sym_cnt == 7'd0
        |-> sx == SCR_X_INIT && sy == SCR_Y_INIT) else $error("Scrambler not restarted.");
    a_no_overflow: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
        push |-> fcnt < 2'd2) else $error("Input stage overflow.");

endmodule : phy_frame_builder
`default_nettype wire

// >>> src/phy_frame_pkg.sv
// Shared constants and types for the physical-layer frame builder.
// Assumes one symbol clock; all counts are in symbols of that clock.
`default_nettype none
package phy_frame_pkg;

    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int          SLOT_LEN     = 90;     // Symbols per slot.
    localparam int          HDR_LEN      = 90;     // Header symbols, one slot.
    localparam int          SOF_LEN      = 26;     // Start-of-frame field of the header.
    localparam int          CODED_LEN    = 64;     // Coded signalling bits of the header.
    localparam int          PILOT_LEN    = 36;     // Symbols per pilot block.
    localparam logic [3:0]  PILOT_EVERY  = 4'hF;   // Last slot index before a pilot block.
    localparam logic [8:0]  DUMMY_SLOTS  = 9'h024; // Payload slots of a dummy frame.

    // Payload slots: code block length over bits per symbol, over 90.
    localparam logic [8:0]  SLOTS_N_QPSK = 9'h168; // 64800/2/90 = 360.
    localparam logic [8:0]  SLOTS_N_8PSK = 9'h0F0; // 64800/3/90 = 240.
    localparam logic [8:0]  SLOTS_N_16A  = 9'h0B4; // 64800/4/90 = 180.
    localparam logic [8:0]  SLOTS_N_32A  = 9'h090; // 64800/5/90 = 144.
    localparam logic [8:0]  SLOTS_S_QPSK = 9'h05A; // 16200/2/90 = 90.
    localparam logic [8:0]  SLOTS_S_8PSK = 9'h03C; // 16200/3/90 = 60.
    localparam logic [8:0]  SLOTS_S_16A  = 9'h02D; // 16200/4/90 = 45.
    localparam logic [8:0]  SLOTS_S_32A  = 9'h024; // 16200/5/90 = 36.

    // ------------------------------------------------------------
    // Symbol format and header patterns
    // ------------------------------------------------------------
    localparam int          SYM_W        = 8;      // Signed width of I and of Q.
    localparam logic [7:0]  AMP          = 8'h5A;  // Amplitude of header, pilot, dummy.
    localparam logic [25:0] SOF_PATTERN  = 26'h2A5F0C3; // Plain default pattern.
    localparam logic [63:0] HDR_SCRAMBLE = 64'hA5C3_96E1_0F5A_3C69; // Plain default.
    localparam logic [17:0] SCR_X_INIT   = 18'h00001;
    localparam logic [17:0] SCR_Y_INIT   = 18'h3FFFF;

    // Input word fields, one entry of the input holding stage.
    localparam int          IN_W         = 25;
    localparam int          F_FIRST      = 24;
    localparam int          F_SHORT      = 23;
    localparam int          F_MOD        = 21;     // Two bits, 22:21.
    localparam int          F_MODCOD     = 16;     // Five bits, 20:16.
    localparam int          F_I          = 8;      // Eight bits, 15:8.

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MOD_QPSK  = 2'h0,
        MOD_8PSK  = 2'h1,
        MOD_16APSK = 2'h2,
        MOD_32APSK = 2'h3
    } mod_t;

    typedef enum logic [2:0] {
        ST_START = 3'h0,
        ST_HDR   = 3'h1,
        ST_DATA  = 3'h2,
        ST_PILOT = 3'h3
    } state_t;

endpackage : phy_frame_pkg
`default_nettype wire

// >>> src/phy_header_encoder.sv
// Header encoder: turns seven signalling bits into the 90 header bits.
// Assumes load_i is a one-cycle pulse; the result is held until the next load.
`timescale 1ns/100ps
`default_nettype none
module phy_header_encoder
    import phy_frame_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Signalling request
    input  wire logic             load_i,
    input  wire logic [4:0]       modcod_i,
    input  wire logic             short_i,
    input  wire logic             pilots_i,
    // Header bits, first symbol in the top bit
    output logic      [HDR_LEN-1:0] hdr_bits_o
);

    // ------------------------------------------------------------
    // Block code
    // ------------------------------------------------------------

    // Each first-order code bit is followed by a copy flipped by the last bit.
    function automatic logic [CODED_LEN-1:0] encode(input logic [6:0] b);
        logic [CODED_LEN-1:0] cw;
        logic [4:0]           j5;
        logic                 yj;
        cw = '0;
        for (int j = 0; j < 32; j++) begin
            j5 = 5'(j);
            yj = (^(b[6:2] & j5)) ^ b[1];
            cw[CODED_LEN-1-2*j] = yj;
            cw[CODED_LEN-2-2*j] = yj ^ b[0];
        end
        return cw;
    endfunction : encode

    logic [HDR_LEN-1:0] next_hdr_bits;

    // A fixed low-rate code keeps the header readable far below payload threshold.
    always_comb begin
        next_hdr_bits = hdr_bits_o;
        if (load_i) begin
            next_hdr_bits = {SOF_PATTERN,
                             encode({modcod_i, short_i, pilots_i}) ^ HDR_SCRAMBLE}; // R4 R5
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hdr_bits_o <= '0;
        end else begin
            hdr_bits_o <= next_hdr_bits;
        end
    end

endmodule : phy_header_encoder
`default_nettype wire
